// ===== tbcc_pkg.sv
// Package with constants, offsets and state encodings of the traversing block command control.
package tbcc_pkg;
    localparam int TBCC_DW = 32;
    localparam int TBCC_AW = 5;
    localparam logic [4:0] TBCC_OFS_CTRL = 5'h00;
    localparam logic [4:0] TBCC_OFS_CFG = 5'h04;
    localparam logic [4:0] TBCC_OFS_SEL = 5'h08;
    localparam logic [4:0] TBCC_OFS_STAT = 5'h0c;
    localparam logic [4:0] TBCC_OFS_WARN = 5'h10;
    localparam int TBCC_SEL_BITS = 8;
    localparam int TBCC_SEL_BITS_OLD = 6;
    localparam int TBCC_BRAKE_CYC = 8;
    localparam logic [3:0] TBCC_BRAKE_MAX = 4'h8;
    localparam int CT_REJECT = 0;
    localparam int CT_ISTOP = 1;
    localparam int CT_START = 2;
    localparam int CT_JOG1 = 3;
    localparam int CT_JOG2 = 4;
    localparam int CT_INCJOG = 5;
    localparam int CT_REFED = 6;
    localparam int CT_REFSTART = 7;
    localparam int CF_NEWVER = 0;
    localparam int CF_WIDE = 1;
    localparam int CF_REJ_MAP = 2;
    localparam int CF_IST_MAP = 3;
    localparam int CF_FROM_BUS = 4;
    localparam logic [1:0] TBCC_RESP_OKAY = 2'b00;
    localparam logic [1:0] TBCC_RESP_SLVERR = 2'b10;
    typedef enum logic [5:0] {
        TBCC_IDLE = 6'b000001,
        TBCC_RUN = 6'b000010,
        TBCC_BRAKE_REJ = 6'b000100,
        TBCC_BRAKE_IST = 6'b001000,
        TBCC_HALT = 6'b010000,
        TBCC_JOG = 6'b100000
    } tbcc_state_t;
    localparam logic [7:0] TBCC_CTRL_RST = 8'h00;
    localparam logic [7:0] TBCC_CFG_RST = 8'h0f;
endpackage

// ===== tbcc_top.sv
// Traversing block command control with AXI4-Lite register access.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Block number is unsigned binary of six or eight weighted selection inputs.
// - Selection bits without an assigned input count as zero.
// - Bus selection word uses low bits only, bits 8 to 15 ignored, unsigned.
// - Reject enable low while running brakes, holds position, discards task, deletes distance.
// - Reject during intermediate stop also deletes remaining distance.
// - While reject is asserted start edges are ignored and nothing starts; here such an edge still sets the start warning.
// - Newer versions treat unmapped reject and stop enables as supplied.
// - Stop enable low while running brakes, holds position, keeps task pending.
// - Rising stop enable edge resumes the interrupted block.
// - In intermediate stop jog or referencing is accepted and abandons the block.
// - Rising start edge starts the block currently selected.
// - Start edge with unmet precondition starts nothing and raises a warning.
// - Setpoint acknowledge toggles only when a block really starts.
// - Incremental select chooses velocity plus increments for both jog channels.
// - Jog channel high traverses at its own speed within positioning mode.
// - Jog rising edge accelerates with maximum acceleration.
// - Jog falling edge brakes with maximum deceleration then restores position control.
// - Software limits and override stay in effect while jogging.
module tbcc_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] term_select,
    input wire logic [7:0] term_select_mapped,
    input wire logic [15:0] block_select_word,
    input wire logic term_reject,
    input wire logic term_istop,
    input wire logic brake_done,
    output logic [7:0] block_number,
    output logic block_start,
    output logic setpoint_ack,
    output logic brake_max_decel,
    output logic delete_distance,
    output logic position_hold,
    output logic jog_active,
    output logic [1:0] jog_channel,
    output logic jog_incremental,
    output logic accel_max,
    output logic limits_active,
    output logic start_warning,
    input wire logic [tbcc_pkg::TBCC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tbcc_pkg::TBCC_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tbcc_pkg::TBCC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tbcc_pkg::TBCC_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tbcc_pkg::*;

    typedef struct packed {
        tbcc_state_t st;
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] prev;
        logic [7:0] blk;
        logic [3:0] brk;
        logic ack;
        logic start;
        logic del;
        logic warn;
        logic [1:0] jch;
        logic aw_got;
        logic w_got;
        logic [4:0] aw_a;
        logic [7:0] w_d;
        logic w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } tbcc_regs_t;

    tbcc_regs_t r;
    tbcc_regs_t next_r;
    logic [7:0] sel_raw;
    logic [7:0] sel_mask;
    logic [7:0] sel_val;
    logic rej_ok;
    logic ist_ok;
    logic start_edge;
    logic ist_rise;
    logic jog_any;
    logic jog_fall;
    logic ref_rise;
    logic start_ok;
    logic [7:0] cur;
    logic warn_set;

    // Selection mask: unmapped terminals and the upper two bits in the older layout read zero.
    genvar gi;
    generate
        for (gi = 0; gi < TBCC_SEL_BITS; gi++) begin : g_sel
            assign sel_mask[gi] = (r.cfg[CF_FROM_BUS] | term_select_mapped[gi]) &
                ((gi < TBCC_SEL_BITS_OLD) ? 1'b1 : r.cfg[CF_WIDE]);
        end
    endgenerate

    // Bus word keeps only its low byte, so a value of 257 selects block 1.
    assign sel_raw = r.cfg[CF_FROM_BUS] ? block_select_word[7:0] : term_select;
    assign sel_val = sel_raw & sel_mask;

    // Unmapped enables count as supplied only in the newer behaviour.
    always_comb begin
        cur = r.ctrl;
        if (r.cfg[CF_REJ_MAP]) begin
            cur[CT_REJECT] = term_reject;
        end
        if (r.cfg[CF_IST_MAP]) begin
            cur[CT_ISTOP] = term_istop;
        end
    end
    assign rej_ok = r.cfg[CF_REJ_MAP] ? term_reject : (r.cfg[CF_NEWVER] | r.ctrl[CT_REJECT]);
    assign ist_ok = r.cfg[CF_IST_MAP] ? term_istop : (r.cfg[CF_NEWVER] | r.ctrl[CT_ISTOP]);

    // Edges come from comparing the present sample with the one of the last cycle.
    assign start_edge = cur[CT_START] & ~r.prev[CT_START];
    assign ist_rise = ist_ok & ~r.prev[CT_ISTOP];
    assign jog_any = cur[CT_JOG1] | cur[CT_JOG2];
    assign jog_fall = (r.prev[CT_JOG1] | r.prev[CT_JOG2]) & ~jog_any;
    assign ref_rise = cur[CT_REFSTART] & ~r.prev[CT_REFSTART];
    assign start_ok = rej_ok & ist_ok & cur[CT_REFED];
    // Any start edge that does not start a block warns, whatever the state, so a halted axis warns too.
    assign warn_set = start_edge & ~(start_ok & (r.st == TBCC_IDLE));

    // Main sequencer together with the AXI4-Lite slave.
    always_comb begin
        next_r = r;
        next_r.prev = cur;
        next_r.prev[CT_ISTOP] = ist_ok;
        next_r.start = 1'b0;
        next_r.del = 1'b0;
        // The warning is sticky until software clears it.
        if (warn_set) begin
            next_r.warn = 1'b1;
        end
        case (r.st)
            TBCC_IDLE: begin
                if (start_edge && start_ok && r.st == TBCC_IDLE) begin
                    next_r.blk = sel_val;
                    next_r.start = 1'b1;
                    next_r.ack = ~r.ack;
                    next_r.st = TBCC_RUN;
                end else if (start_edge) begin
                    next_r.warn = 1'b1;
                end else if (jog_any) begin
                    next_r.jch = {cur[CT_JOG2], cur[CT_JOG1]};
                    next_r.st = TBCC_JOG;
                end
            end
            TBCC_RUN: begin
                if (start_edge) begin
                    next_r.warn = 1'b1;
                end
                if (!rej_ok) begin
                    next_r.st = TBCC_BRAKE_REJ;
                    next_r.brk = TBCC_BRAKE_MAX;
                end else if (!ist_ok) begin
                    next_r.st = TBCC_BRAKE_IST;
                    next_r.brk = TBCC_BRAKE_MAX;
                end else if (brake_done) begin
                    next_r.st = TBCC_IDLE;
                end
            end
            TBCC_BRAKE_REJ: begin
                if (brake_done || r.brk == 4'h0) begin
                    next_r.del = 1'b1;
                    next_r.st = TBCC_IDLE;
                end else begin
                    next_r.brk = r.brk - 4'h1;
                end
            end
            TBCC_BRAKE_IST, TBCC_HALT: begin
                if (r.st == TBCC_BRAKE_IST && r.brk != 4'h0 && !brake_done) begin
                    next_r.brk = r.brk - 4'h1;
                end else begin
                    next_r.st = TBCC_HALT;
                end
                if (!rej_ok) begin
                    next_r.del = 1'b1;
                    next_r.st = TBCC_IDLE;
                end else if (jog_any || ref_rise) begin
                    next_r.del = 1'b1;
                    next_r.jch = {cur[CT_JOG2], cur[CT_JOG1]};
                    next_r.st = jog_any ? TBCC_JOG : TBCC_IDLE;
                end else if (ist_rise) begin
                    next_r.st = TBCC_RUN;
                end
            end
            TBCC_JOG: begin
                if (jog_fall) begin
                    next_r.st = TBCC_BRAKE_REJ;
                    next_r.brk = TBCC_BRAKE_MAX;
                end
            end
            default: begin
                next_r.st = TBCC_IDLE;
            end
        endcase

        // Write channel: address and data may arrive in either order.
        if (s_axi_awvalid && !r.aw_got) begin
            next_r.aw_got = 1'b1;
            next_r.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got) begin
            next_r.w_got = 1'b1;
            next_r.w_d = s_axi_wdata[7:0];
            next_r.w_s = s_axi_wstrb[0];
        end
        if (r.aw_got && r.w_got && !r.bv) begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bv = 1'b1;
            next_r.br = TBCC_RESP_OKAY;
            case (r.aw_a)
                TBCC_OFS_CTRL: begin
                    if (r.w_s) begin
                        next_r.ctrl = r.w_d;
                    end
                end
                TBCC_OFS_CFG: begin
                    if (r.w_s) begin
                        next_r.cfg = r.w_d;
                    end
                end
                TBCC_OFS_WARN: begin
                    // A new warning in the same cycle wins over the clear.
                    if (r.w_s && r.w_d[0] && !warn_set) begin
                        next_r.warn = 1'b0;
                    end
                end
                TBCC_OFS_SEL, TBCC_OFS_STAT: begin
                    next_r.br = TBCC_RESP_OKAY;
                end
                default: begin
                    next_r.br = TBCC_RESP_SLVERR;
                end
            endcase
        end
        if (r.bv && s_axi_bready) begin
            next_r.bv = 1'b0;
        end

        // Read channel: one read in flight, answered the cycle after it is taken.
        if (s_axi_arvalid && !r.rv) begin
            next_r.rv = 1'b1;
            next_r.rr = TBCC_RESP_OKAY;
            case (s_axi_araddr)
                TBCC_OFS_CTRL: next_r.rd = {24'h000000, r.ctrl};
                TBCC_OFS_CFG: next_r.rd = {24'h000000, r.cfg};
                TBCC_OFS_SEL: next_r.rd = {24'h000000, sel_val};
                TBCC_OFS_STAT: next_r.rd = {16'h0000, r.blk, 2'b00, r.st};
                TBCC_OFS_WARN: next_r.rd = {30'h00000000, r.ack, r.warn};
                default: begin
                    next_r.rd = 32'h00000000;
                    next_r.rr = TBCC_RESP_SLVERR;
                end
            endcase
        end else if (r.rv && s_axi_rready) begin
            next_r.rv = 1'b0;
        end
    end

    // State register; every field takes a constant under reset.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.st <= TBCC_IDLE;
            r.ctrl <= TBCC_CTRL_RST;
            r.cfg <= TBCC_CFG_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs are state flip-flops or decodes of them; limits_active is tied high.
    assign block_number = r.blk;
    assign block_start = r.start;
    assign setpoint_ack = r.ack;
    assign brake_max_decel = (r.st == TBCC_BRAKE_REJ) || (r.st == TBCC_BRAKE_IST);
    assign delete_distance = r.del;
    assign position_hold = (r.st != TBCC_JOG) && (r.st != TBCC_RUN);
    assign jog_active = (r.st == TBCC_JOG);
    assign jog_channel = r.jch;
    assign jog_incremental = r.ctrl[CT_INCJOG];
    assign accel_max = (r.st == TBCC_JOG);
    assign limits_active = 1'b1;
    assign start_warning = r.warn;
    assign s_axi_awready = ~r.aw_got;
    assign s_axi_wready = ~r.w_got;
    assign s_axi_bvalid = r.bv;
    assign s_axi_bresp = r.br;
    assign s_axi_arready = ~r.rv;
    assign s_axi_rvalid = r.rv;
    assign s_axi_rdata = r.rd;
    assign s_axi_rresp = r.rr;

    // A start is granted only with both enables and the reference present.
    a_start_needs_ok: assert property (@(posedge mclk) disable iff (!nrst)
        next_r.start |-> start_ok) else $error("block started without preconditions");
    a_ack_on_start: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(setpoint_ack) |-> block_start) else $error("ack changed without start");
    a_reject_blocks: assert property (@(posedge mclk) disable iff (!nrst)
        !rej_ok |=> !block_start) else $error("start while rejecting");
    a_warn_on_fail: assert property (@(posedge mclk) disable iff (!nrst)
        (start_edge && !start_ok) |=> start_warning) else $error("missing warning");
    a_start_number: assert property (@(posedge mclk) disable iff (!nrst)
        next_r.start |=> block_number == $past(sel_val)) else $error("wrong block");
    sequence s_halted;
        r.st == TBCC_HALT;
    endsequence
    a_resume_halt: assert property (@(posedge mclk) disable iff (!nrst)
        s_halted ##0 (rej_ok && !jog_any && !ref_rise && ist_rise) |=> r.st == TBCC_RUN)
        else $error("no resume");
    a_reject_delete: assert property (@(posedge mclk) disable iff (!nrst)
        (s_halted ##0 !rej_ok) |=> delete_distance) else $error("no delete");
    a_jog_brake: assert property (@(posedge mclk) disable iff (!nrst)
        (jog_active && jog_fall) |=> brake_max_decel ##[1:9] position_hold)
        else $error("jog stop bad");
    a_bus_low_byte: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg[CF_FROM_BUS] |-> (sel_val & ~block_select_word[7:0]) == 8'h00)
        else $error("select word misuse");
endmodule // tbcc_top
`default_nettype wire

// ===== tbcc_motion_model.sv
// Behavioural motion side that reports when a run or a braking ramp has finished.
`timescale 1ns/1ns
`default_nettype none
module tbcc_motion_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic position_hold,
    input wire logic jog_active,
    input wire logic brake_max_decel,
    input wire logic [7:0] delay,
    output logic brake_done
);
    logic [7:0] cnt;
    logic brake_q;
    // Completion comes delay+1 cycles after a run or delay+2 after a ramp begins, so the bench picks prompt
    // or slow answers; a held jog never completes, only its release can end it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            brake_q <= 1'b0;
            brake_done <= 1'b0;
        end else begin
            brake_q <= brake_max_decel;
            brake_done <= 1'b0;
            if (brake_max_decel != brake_q || !(brake_max_decel || !(position_hold || jog_active))) begin
                cnt <= 8'h00;
            end else if (cnt == delay) begin
                brake_done <= 1'b1;
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule // tbcc_motion_model
`default_nettype wire

// ===== traversing_block_command_control_tb.sv
// Self-checking testbench of the traversing block command control.
`timescale 1ns/1ns
`default_nettype none
module traversing_block_command_control_tb;
    import tbcc_pkg::*;
    logic mclk, nrst = 0, brake_done, block_start, setpoint_ack, brake_max_decel, delete_distance;
    logic position_hold, jog_active, jog_incremental, accel_max, limits_active, start_warning;
    logic term_reject = 1, term_istop = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic aw_r, w_r, b_v, ar_r, r_v;
    logic [7:0] term_select = 0, term_select_mapped = 8'hff, delay = 8'h03, block_number;
    logic [15:0] block_select_word = 0;
    logic [1:0] jog_channel, b_resp, r_resp;
    logic [4:0] aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0, r_d, rv;
    logic [1:0] rr;
    int errors = 0, num_checks = 0, n_start = 0, n_del = 0;
    tbcc_top dut (.mclk(mclk), .nrst(nrst), .term_select(term_select),
        .term_select_mapped(term_select_mapped), .block_select_word(block_select_word),
        .term_reject(term_reject), .term_istop(term_istop), .brake_done(brake_done),
        .block_number(block_number), .block_start(block_start), .setpoint_ack(setpoint_ack),
        .brake_max_decel(brake_max_decel), .delete_distance(delete_distance),
        .position_hold(position_hold), .jog_active(jog_active), .jog_channel(jog_channel),
        .jog_incremental(jog_incremental), .accel_max(accel_max), .limits_active(limits_active),
        .start_warning(start_warning), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
    tbcc_motion_model motion (.mclk(mclk), .nrst(nrst), .position_hold(position_hold),
        .jog_active(jog_active), .brake_max_decel(brake_max_decel), .delay(delay),
        .brake_done(brake_done));
    // Free-running 100 MHz clock.
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    // Start pulses and distance deletions are single-cycle, so they are counted as they pass.
    always @(posedge mclk) begin
        if (block_start === 1'b1) n_start++;
        if (delete_distance === 1'b1) n_del++;
    end
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Address and data are offered together and each is dropped as soon as it is taken.
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge mclk);
            if (aw_r && aw_v) aw_v <= 1'b0;
            if (w_r && w_v) w_v <= 1'b0;
        end while (b_v !== 1'b1);
        b_r <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, b_resp});
        @(posedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge mclk);
            if (ar_r && ar_v) ar_v <= 1'b0;
        end while (r_v !== 1'b1);
        rv = r_d;
        rr = r_resp;
        r_r <= 1'b0;
        chk("rdata", e, rv);
        chk("rresp", {30'h0, er}, {30'h0, rr});
        @(posedge mclk);
    endtask
    // The start bit is dropped first so that the second write is a clean rising edge.
    task automatic go(input logic [7:0] c);
        wr(TBCC_OFS_CTRL, {24'h0, c}, TBCC_RESP_OKAY);
        wr(TBCC_OFS_CTRL, {24'h0, c | 8'h04}, TBCC_RESP_OKAY);
        wt(6);
    endtask
    task automatic t_regs();
        rd(TBCC_OFS_CTRL, 32'h0, TBCC_RESP_OKAY);
        rd(TBCC_OFS_CFG, 32'h0f, TBCC_RESP_OKAY);
        rd(5'h14, 32'h0, TBCC_RESP_SLVERR);
        wr(5'h14, 32'hff, TBCC_RESP_SLVERR);
        chk("limits", 32'h1, {31'h0, limits_active});
    endtask
    task automatic t_select();
        term_select <= 8'hff;
        term_select_mapped <= 8'h0f;
        wt(3);
        rd(TBCC_OFS_SEL, 32'h0f, TBCC_RESP_OKAY);
        term_select_mapped <= 8'hff;
        wr(TBCC_OFS_CFG, 32'h0d, TBCC_RESP_OKAY);
        rd(TBCC_OFS_SEL, 32'h3f, TBCC_RESP_OKAY);
        block_select_word <= 16'hff81;
        wr(TBCC_OFS_CFG, 32'h1f, TBCC_RESP_OKAY);
        rd(TBCC_OFS_SEL, 32'h81, TBCC_RESP_OKAY);
        wr(TBCC_OFS_CFG, 32'h0f, TBCC_RESP_OKAY);
    endtask
    task automatic t_start();
        int s0;
        logic a0;
        term_select <= 8'ha5;
        s0 = n_start;
        a0 = setpoint_ack;
        go(8'h40);
        chk("starts", s0 + 1, n_start);
        chk("block", 32'ha5, {24'h0, block_number});
        chk("ack", {31'h0, ~a0}, {31'h0, setpoint_ack});
        wr(TBCC_OFS_CTRL, 32'h44, TBCC_RESP_OKAY);
        wt(6);
        chk("starts", s0 + 1, n_start);
    endtask
    task automatic t_refuse();
        int s0;
        s0 = n_start;
        term_reject <= 1'b0;
        go(8'h40);
        chk("starts", s0, n_start);
        chk("warn", 32'h1, {31'h0, start_warning});
        wr(TBCC_OFS_WARN, 32'h1, TBCC_RESP_OKAY);
        rd(TBCC_OFS_WARN, {30'h0, setpoint_ack, 1'b0}, TBCC_RESP_OKAY);
        term_reject <= 1'b1;
        go(8'h00);
        chk("starts", s0, n_start);
        chk("warn", 32'h1, {31'h0, start_warning});
        wr(TBCC_OFS_WARN, 32'h1, TBCC_RESP_OKAY);
    endtask
    task automatic t_version();
        int s0;
        s0 = n_start;
        term_reject <= 1'b0;
        term_istop <= 1'b0;
        wr(TBCC_OFS_CFG, 32'h01, TBCC_RESP_OKAY);
        go(8'h40);
        chk("starts", s0 + 1, n_start);
        wr(TBCC_OFS_CFG, 32'h00, TBCC_RESP_OKAY);
        go(8'h40);
        chk("starts", s0 + 1, n_start);
        wr(TBCC_OFS_CFG, 32'h0f, TBCC_RESP_OKAY);
        wr(TBCC_OFS_WARN, 32'h1, TBCC_RESP_OKAY);
        term_reject <= 1'b1;
        term_istop <= 1'b1;
    endtask
    // Runs a block slowly, then halts it with a quick ramp so the halt is reached in time.
    task automatic halt_run();
        delay <= 8'h1e;
        go(8'h40);
        chk("hold", 32'h0, {31'h0, position_hold});
        delay <= 8'h03;
        term_istop <= 1'b0;
        wt(4);
        chk("brake", 32'h1, {31'h0, brake_max_decel});
        wt(8);
    endtask
    task automatic t_stop();
        int d0;
        d0 = n_del;
        halt_run();
        chk("hold", 32'h1, {31'h0, position_hold});
        chk("deletes", d0, n_del);
        delay <= 8'h1e;
        term_istop <= 1'b1;
        wt(4);
        chk("hold", 32'h0, {31'h0, position_hold});
        // Motion side stays slow so the run cannot finish inside the reject ramp.
        term_reject <= 1'b0;
        wt(4);
        chk("brake", 32'h1, {31'h0, brake_max_decel});
        wt(10);
        chk("deletes", d0 + 1, n_del);
        chk("hold", 32'h1, {31'h0, position_hold});
        term_reject <= 1'b1;
        halt_run();
        term_reject <= 1'b0;
        wt(4);
        chk("deletes", d0 + 2, n_del);
        term_reject <= 1'b1;
        term_istop <= 1'b1;
        halt_run();
        wr(TBCC_OFS_CTRL, 32'h4c, TBCC_RESP_OKAY);
        wt(4);
        chk("deletes", d0 + 3, n_del);
        chk("jog", 32'h1, {31'h0, jog_active});
        term_istop <= 1'b1;
        wr(TBCC_OFS_CTRL, 32'h40, TBCC_RESP_OKAY);
        wt(12);
        halt_run();
        wr(TBCC_OFS_CTRL, 32'hc4, TBCC_RESP_OKAY);
        wt(4);
        chk("deletes", d0 + 5, n_del);
        chk("jog", 32'h0, {31'h0, jog_active});
        term_istop <= 1'b1;
        wt(2);
    endtask
    task automatic t_jog();
        wr(TBCC_OFS_CTRL, 32'h68, TBCC_RESP_OKAY);
        wt(3);
        chk("jog", 32'h1, {31'h0, jog_active});
        chk("chan", 32'h1, {30'h0, jog_channel});
        chk("incr", 32'h1, {31'h0, jog_incremental});
        chk("accel", 32'h1, {31'h0, accel_max});
        chk("limits", 32'h1, {31'h0, limits_active});
        wr(TBCC_OFS_CTRL, 32'h40, TBCC_RESP_OKAY);
        wt(2);
        chk("brake", 32'h1, {31'h0, brake_max_decel});
        wt(10);
        chk("hold", 32'h1, {31'h0, position_hold});
        wr(TBCC_OFS_CTRL, 32'h50, TBCC_RESP_OKAY);
        wt(3);
        chk("chan", 32'h2, {30'h0, jog_channel});
        chk("incr", 32'h0, {31'h0, jog_incremental});
        wr(TBCC_OFS_CTRL, 32'h40, TBCC_RESP_OKAY);
        wt(12);
    endtask
    // Main sequence; reset is held for five cycles before the first request.
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_select();
        t_start();
        t_refuse();
        t_version();
        t_stop();
        t_jog();
        print_verdict();
    end
    // Whole run needs fewer than four hundred cycles, so this only trips on a hang.
    initial begin
        repeat (8000) @(posedge mclk);
        errors++;
        print_verdict();
    end
endmodule // traversing_block_command_control_tb
`default_nettype wire
